// >>> hdl/sdq_cfg.svh
/*
  Constants for the delta-sigma conversion sequencer: register offsets,
  field positions, reset values and timing counts.
  Assumes inclusion by bare name from the package and the sequencer.
*/
`ifndef SDQ_CFG_SVH
`define SDQ_CFG_SVH

`define SDQ_OFS_CTRL 8'h00
`define SDQ_OFS_STAT 8'h04
`define SDQ_OFS_RESULT 8'h08
`define SDQ_OFS_IRQ_STAT 8'h0C
`define SDQ_OFS_IRQ_CLR 8'h10
`define SDQ_OFS_IRQ_EN 8'h14
`define SDQ_OFS_DIV 8'h18

`define SDQ_CTRL_START 0
`define SDQ_CTRL_ENABLE 1
`define SDQ_CTRL_MODE_LO 2
`define SDQ_CTRL_MODE_HI 3
`define SDQ_CTRL_RES8 4

`define SDQ_IRQ_DONE 0
`define SDQ_IRQ_OVERRUN 1

`define SDQ_PRIME_CONV 3'h3
`define SDQ_DEC_LEN12 8'h80
`define SDQ_DEC_LEN8 8'h40
`define SDQ_DIV_RESET 8'h00
`define SDQ_CIC_W 32

`endif

// >>> hdl/sdq_pkg.sv
/*
  Types for the delta-sigma conversion sequencer.
  Assumes sdq_cfg.svh is on the include path.
*/
package sdq_pkg;
  `include "sdq_cfg.svh"

  typedef enum logic [1:0] {
    SDQ_MODE_SINGLE = 2'h0,
    SDQ_MODE_CONT = 2'h1,
    SDQ_MODE_MULTI = 2'h2,
    SDQ_MODE_TURBO = 2'h3
  } sdq_mode_t;

  // Gray along idle -> prime -> run -> hold
  typedef enum logic [1:0] {
    SDQ_ST_IDLE = 2'b00,
    SDQ_ST_PRIME = 2'b01,
    SDQ_ST_RUN = 2'b11,
    SDQ_ST_HOLD = 2'b10
  } sdq_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
  } sdq_req_t;
endpackage

// >>> hdl/sdq_sequencer.sv
/*
  Conversion sequencer and sinc4 decimator for a delta-sigma ADC, with an
  AHB-Lite register slave, sticky interrupt status, a done output that also
  serves as an interrupt or DMA request, and a result validity flag.
  Assumes modBit is synchronous to sys_clk, one modulator bit per clock,
  startConv and muxSwitched synchronous to sys_clk as well,
  and a single AHB-Lite master issuing word transfers with zero wait states.
*/
// Operation
// - Four modes: single, continuous, multi, turbo multi
// - Start by control bit or start input
// - Done flag and output held until read
// - Single: standby, four conversions, three prime
// - Single: result valid after fourth conversion
// - Single: after read, back to standby
// - Continuous: three priming periods, then each rate
// - Multi: reset and re-prime between samples
// - Multi: next sample starts automatically
// - After mux switch, fourth sample first valid
// - Decimate serial bitstream into parallel results
// - Fourth-order sinc response
// - 12-bit at base rate, 8-bit twice rate
// - Done output usable as interrupt/DMA request
`timescale 1ns/100ps
`include "sdq_cfg.svh"
module sdq_sequencer
  import sdq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic modBit,
  input wire logic startConv,
  input wire logic muxSwitched,
  output logic convDone,
  output logic dataValid,
  output logic irq
);
  sdq_req_t req_q;
  logic dphase_q;
  logic [4:0] ctrl_q;
  logic [7:0] div_q;
  logic [1:0] irqStat_q;
  logic [1:0] irqEn_q;
  logic [15:0] result_q;
  logic done_q;
  logic overrun_q;
  sdq_state_t state_q;
  logic [2:0] primeCnt_q;
  logic [7:0] phase_q;
  logic [2:0] validCnt_q;
  logic [`SDQ_CIC_W-1:0] integ_q [4];
  logic [`SDQ_CIC_W-1:0] comb_q [4];
  logic [`SDQ_CIC_W-1:0] combIn [5];
  logic [`SDQ_CIC_W-1:0] integIn [5];
  logic wrCtrl;
  logic wrClr;
  logic wrEn;
  logic wrDiv;
  logic rdResult;
  logic startReq;
  logic convEnd;
  logic seqReset;
  logic resultLoad;
  logic [1:0] irqEvt;
  logic [1:0] irqClr;
  logic [1:0] irqStat_d;
  logic [31:0] statWord;
  logic [7:0] decLen;
  sdq_mode_t mode;

  assign mode = sdq_mode_t'(ctrl_q[`SDQ_CTRL_MODE_HI:`SDQ_CTRL_MODE_LO]);
  // Lower resolution trades for shorter decimation, twice the rate
  assign decLen = ctrl_q[`SDQ_CTRL_RES8] ? `SDQ_DEC_LEN8 : `SDQ_DEC_LEN12;

  // Zero-wait slave; every access is OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      req_q <= '0;
      dphase_q <= 1'b0;
    end else if (hready) begin
      dphase_q <= hsel & htrans[1];
      req_q.addr <= haddr[7:0];
      req_q.write <= hwrite;
    end
  end

  assign wrCtrl = dphase_q & req_q.write & (req_q.addr == `SDQ_OFS_CTRL);
  assign wrClr = dphase_q & req_q.write & (req_q.addr == `SDQ_OFS_IRQ_CLR);
  assign wrEn = dphase_q & req_q.write & (req_q.addr == `SDQ_OFS_IRQ_EN);
  assign wrDiv = dphase_q & req_q.write & (req_q.addr == `SDQ_OFS_DIV);
  assign rdResult = dphase_q & ~req_q.write & (req_q.addr == `SDQ_OFS_RESULT);

  // Status word; state bits let software see a stuck sequence
  assign statWord = {
    26'h000_0000,
    validCnt_q == 3'h4,
    state_q,
    dataValid,
    overrun_q,
    done_q
  };

  always_comb begin
    hrdata = 32'h0000_0000;
    if (dphase_q && !req_q.write) begin
      case (req_q.addr)
        `SDQ_OFS_CTRL: hrdata = {27'h000_0000, ctrl_q};
        `SDQ_OFS_STAT: hrdata = statWord;
        `SDQ_OFS_RESULT: hrdata = {16'h0000, result_q};
        `SDQ_OFS_IRQ_STAT: hrdata = {30'h0000_0000, irqStat_q};
        `SDQ_OFS_IRQ_EN: hrdata = {30'h0000_0000, irqEn_q};
        `SDQ_OFS_DIV: hrdata = {24'h00_0000, div_q};
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Start bit self-clears so one write is one trigger
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= '0;
    end else if (wrCtrl) begin
      ctrl_q <= hwdata[4:0];
    end else begin
      ctrl_q[`SDQ_CTRL_START] <= 1'b0;
    end
  end

  // Spare divider word; kept readable so software can park a value there
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_q <= `SDQ_DIV_RESET;
    end else if (wrDiv) begin
      div_q <= hwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irqEn_q <= '0;
    end else if (wrEn) begin
      irqEn_q <= hwdata[1:0];
    end
  end

  assign startReq = ctrl_q[`SDQ_CTRL_START] | startConv;

  // Conversion period counter; a sample ends when phase wraps
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_q <= '0;
    end else if (seqReset || phase_q == decLen - 8'h01) begin
      phase_q <= '0;
    end else begin
      phase_q <= phase_q + 8'h01;
    end
  end
  assign convEnd = (state_q == SDQ_ST_PRIME || state_q == SDQ_ST_RUN) && phase_q == decLen - 8'h01;

  // Four integrators at bit rate, four combs at output rate: sinc4
  // Wrap-around in the integrators is harmless: the combs subtract it out
  assign integIn[0] = {{(`SDQ_CIC_W-1){1'b0}}, modBit};
  assign combIn[0] = integIn[4];
  generate
    for (genvar i = 0; i < 4; i++) begin : g_stage
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          integ_q[i] <= '0;
          comb_q[i] <= '0;
        end else if (seqReset) begin
          integ_q[i] <= '0;
          comb_q[i] <= '0;
        end else begin
          integ_q[i] <= integ_q[i] + integIn[i];
          if (convEnd) comb_q[i] <= combIn[i];
        end
      end
      assign integIn[i+1] = integ_q[i];
      assign combIn[i+1] = combIn[i] - comb_q[i];
    end
  endgenerate

  // Sequence state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= SDQ_ST_IDLE;
      primeCnt_q <= '0;
    end else if (!ctrl_q[`SDQ_CTRL_ENABLE]) begin
      state_q <= SDQ_ST_IDLE;
      primeCnt_q <= '0;
    end else begin
      case (state_q)
        SDQ_ST_IDLE: begin
          if (startReq) begin
            state_q <= SDQ_ST_PRIME;
            primeCnt_q <= '0;
          end
        end
        SDQ_ST_PRIME: begin
          if (convEnd) begin
            primeCnt_q <= primeCnt_q + 3'h1;
            if (primeCnt_q == `SDQ_PRIME_CONV - 3'h1) state_q <= SDQ_ST_RUN;
          end
        end
        SDQ_ST_RUN: begin
          if (convEnd) begin
            case (mode)
              SDQ_MODE_SINGLE: state_q <= SDQ_ST_HOLD;
              SDQ_MODE_CONT: state_q <= SDQ_ST_RUN;
              default: begin
                state_q <= SDQ_ST_PRIME;
                primeCnt_q <= '0;
              end
            endcase
          end
        end
        SDQ_ST_HOLD: begin
          if (rdResult) state_q <= SDQ_ST_IDLE;
        end
        default: state_q <= SDQ_ST_IDLE;
      endcase
    end
  end

  // Filter restarts on every fresh sequence and between multi samples
  assign seqReset = (state_q == SDQ_ST_IDLE) ||
    (state_q == SDQ_ST_RUN && convEnd && (mode == SDQ_MODE_MULTI || mode == SDQ_MODE_TURBO));

  // Mux switch restarts the four-sample validity count
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      validCnt_q <= '0;
    end else if (muxSwitched || seqReset) begin
      validCnt_q <= '0;
    end else if (convEnd && validCnt_q != 3'h4) begin
      validCnt_q <= validCnt_q + 3'h1;
    end
  end

  // Every run-state period delivers a result: the fourth of a sequence, then each one in continuous mode
  assign resultLoad = (state_q == SDQ_ST_RUN) && convEnd;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      result_q <= '0;
    end else if (resultLoad) begin
      result_q <= ctrl_q[`SDQ_CTRL_RES8] ? {8'h00, combIn[4][24:17]} : {4'h0, combIn[4][27:16]};
    end
  end

  // Done and overrun; a new result wins over a same-cycle read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
      overrun_q <= 1'b0;
    end else if (resultLoad) begin
      done_q <= 1'b1;
      overrun_q <= done_q;
    end else if (rdResult) begin
      done_q <= 1'b0;
      overrun_q <= 1'b0;
    end
  end

  // A mux switch drops validity at once rather than at the next result
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dataValid <= 1'b0;
    end else if (resultLoad) begin
      dataValid <= !muxSwitched && (validCnt_q == 3'h3 || validCnt_q == 3'h4);
    end else if (muxSwitched) begin
      dataValid <= 1'b0;
    end
  end
  assign convDone = done_q;

  always_comb begin
    irqEvt = 2'h0;
    irqEvt[`SDQ_IRQ_DONE] = resultLoad;
    irqEvt[`SDQ_IRQ_OVERRUN] = resultLoad & done_q;
  end
  assign irqClr = wrClr ? hwdata[1:0] : 2'h0;

  // Sticky status: set wins over clear, so an event is never lost to a late clear
  assign irqStat_d = irqEvt | (irqStat_q & ~irqClr);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irqStat_q <= '0;
    end else begin
      irqStat_q <= irqStat_d;
    end
  end
  assign irq = |(irqStat_q & irqEn_q);
endmodule

// >>> sim/sdq_sequencer_properties.sv
/* Port checker for the conversion sequencer.
   Assumes a bind into sdq_sequencer and word-wide AHB reads. */
`timescale 1ns/100ps
`include "sdq_cfg.svh"
module sdq_checker(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic muxSwitched,
  input wire logic convDone,
  input wire logic dataValid
);
  logic rdPhase_q;
  logic doneOld_q;
  logic seen_q;
  logic [7:0] adr_q;
  logic [9:0] gap_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdPhase_q <= 1'b0;
      adr_q <= 8'h00;
    end else begin
      rdPhase_q <= hready && hsel && htrans[1] && !hwrite;
      adr_q <= haddr[7:0];
    end
  end
  // Saturates so a long idle never wraps into a false short gap
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gap_q <= 10'h000;
      seen_q <= 1'b0;
      doneOld_q <= 1'b0;
    end else begin
      doneOld_q <= convDone;
      if (convDone && !doneOld_q) begin
        gap_q <= 10'h001;
        seen_q <= 1'b1;
      end else if (gap_q != 10'h3ff) begin
        gap_q <= gap_q + 10'h001;
      end
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_doneHold; convDone && !(rdPhase_q && adr_q == `SDQ_OFS_RESULT) |=> convDone; endproperty
  a_doneHold: assert property (p_doneHold) else $error("done dropped unread");
  property p_muxInvalid; muxSwitched |=> !dataValid [*8]; endproperty
  a_muxInvalid: assert property (p_muxInvalid) else $error("valid after switch");
  property p_firstDone; $rose(convDone) && !seen_q |-> gap_q >= 10'h100; endproperty
  a_firstDone: assert property (p_firstDone) else $error("result before priming");
  property p_gap; $rose(convDone) && seen_q |-> gap_q >= 10'h040; endproperty
  a_gap: assert property (p_gap) else $error("results too close");
  property p_resWidth; rdPhase_q && adr_q == `SDQ_OFS_RESULT |-> hrdata[31:12] == 20'h0_0000; endproperty
  a_resWidth: assert property (p_resWidth) else $error("result too wide");
  property p_statDone; rdPhase_q && adr_q == `SDQ_OFS_STAT |-> hrdata[0] == convDone; endproperty
  a_statDone: assert property (p_statDone) else $error("done status mismatch");
  property p_statValid; rdPhase_q && adr_q == `SDQ_OFS_STAT |-> hrdata[2] == dataValid; endproperty
  a_statValid: assert property (p_statValid) else $error("valid status mismatch");
  property p_rdIdle; !rdPhase_q |-> hrdata == 32'h0000_0000; endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside phase");
endmodule
bind sdq_sequencer sdq_checker sdq_checker_inst(.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hrdata, .muxSwitched, .convDone, .dataValid);

// >>> sim/sdq_soc_src.sv
/* Start source standing in for the programmable logic.
   Assumes fire is driven by the bench on sys_clk. */
`timescale 1ns/100ps
module sdq_soc_src(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic fire,
  output logic startConv
);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      startConv <= 1'b0;
    end else begin
      startConv <= fire;
    end
  end
endmodule

// >>> sim/sdq_sequencer_tb.sv
/* Self-checking bench for the conversion sequencer.
   Assumes the package, the checker and the start source are compiled first. */
`timescale 1ns/100ps
`include "sdq_cfg.svh"
module sdq_sequencer_tb import sdq_pkg::*; ;
  logic sys_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, modBit = 1'b0, muxSwitched = 1'b0, fire = 1'b0;
  logic startConv, convDone, dataValid, irq, hreadyout, hresp;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, r, xs = 32'h0000_e056;
  logic [1:0] htrans = 2'h0;
  int err_total = 0, checked = 0, cyc = 0, n;
  sdq_sequencer sdq_sequencer_inst(.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .modBit, .startConv, .muxSwitched, .convDone, .dataValid, .irq);
  sdq_soc_src sdq_soc_src_inst(.sys_clk, .rst, .fire, .startConv);
  always #20 sys_clk = ~sys_clk;
  function automatic logic [31:0] nxt(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  // Start, enable and 8-bit length keep each run short
  function automatic logic [31:0] ctl(input int m);
    return 32'h0000_0013 | (32'(m) << 2);
  endfunction
  function automatic logic nextOk(input int m, input int k);
    return m == 0 ? k == 400 : m == 1 ? k <= 64 : (k >= 200 && k <= 270);
  endfunction
  task finish_test;
    if (err_total == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    xs <= nxt(xs);
    modBit <= xs[0];
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      finish_test;
    end
  end
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    // Read data still stands in the time step of this edge
    r = hrdata;
  endtask
  task waitDone(input int lim);
    n = 0;
    while (convDone !== 1'b1 && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    bus(`SDQ_OFS_CTRL, 1'b0, 32'h0000_0000);
    chk("ctrl", 32'h0000_0000, r);
    chk("resp", 32'h0000_0000, 32'(hresp));
    bus(8'h1C, 1'b0, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, r);
    for (int m = 0; m < 4; m++) begin
      bus(`SDQ_OFS_IRQ_EN, 1'b1, 32'h0000_0001);
      bus(`SDQ_OFS_CTRL, 1'b1, ctl(m));
      waitDone(400);
      chk("latency", 32'h0000_0001, 32'(n >= 250 && n <= 270));
      chk("irq", 32'h0000_0001, 32'(irq));
      bus(`SDQ_OFS_STAT, 1'b0, 32'h0000_0000);
      chk("stat", 32'h0000_0001, r & 32'h0000_0001);
      bus(`SDQ_OFS_RESULT, 1'b0, 32'h0000_0000);
      chk("res8", 32'h0000_0000, r & 32'hFFFF_FF00);
      @(negedge sys_clk);
      chk("cleared", 32'h0000_0000, 32'(convDone));
      waitDone(400);
      chk("next", 32'h0000_0001, 32'(nextOk(m, n)));
      bus(`SDQ_OFS_CTRL, 1'b1, 32'h0000_0000);
      bus(`SDQ_OFS_RESULT, 1'b0, 32'h0000_0000);
      bus(`SDQ_OFS_IRQ_CLR, 1'b1, 32'h0000_0003);
      @(negedge sys_clk);
      chk("irqclr", 32'h0000_0000, 32'({convDone, irq}));
    end
    bus(`SDQ_OFS_IRQ_EN, 1'b1, 32'h0000_0000);
    bus(`SDQ_OFS_CTRL, 1'b1, 32'h0000_0012);
    @(posedge sys_clk);
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    waitDone(400);
    chk("socdone", 32'h0000_0001, 32'(convDone));
    chk("validset", 32'h0000_0001, 32'(dataValid));
    chk("masked", 32'h0000_0000, 32'(irq));
    bus(`SDQ_OFS_IRQ_EN, 1'b1, 32'h0000_0001);
    @(negedge sys_clk);
    chk("unmask", 32'h0000_0001, 32'(irq));
    @(posedge sys_clk);
    muxSwitched <= 1'b1; // Pulsed only outside continuous mode
    @(posedge sys_clk);
    muxSwitched <= 1'b0;
    @(negedge sys_clk);
    chk("valid", 32'h0000_0000, 32'(dataValid));
    finish_test;
  end
endmodule
